/* inc/cbx_pkg.sv */
// Constants, command layout and state encoding of the bit/shift/load execution block
package cbx_pkg;
   // Control register byte addresses
   localparam logic [11:0] ADDR_CMD = 12'h000;
   localparam logic [11:0] ADDR_FLAGS = 12'h004;
   localparam logic [11:0] ADDR_PC = 12'h008;
   localparam logic [11:0] ADDR_STAT = 12'h00C;
   // Window tags: register file 0x100..0x17C, I/O 0x200..0x2FC, data memory 0x400..0x7FC
   localparam logic [4:0] RF_TAG = 5'h02;
   localparam logic [3:0] IO_TAG = 4'h2;
   localparam logic [1:0] DM_TAG = 2'h1;
   localparam logic [7:0] CSR_TAG = 8'h00;
   // Reset values
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;
   // Status flag positions
   localparam logic [2:0] FL_C = 3'h0;
   localparam logic [2:0] FL_Z = 3'h1;
   localparam logic [2:0] FL_N = 3'h2;
   localparam logic [2:0] FL_V = 3'h3;
   localparam logic [2:0] FL_S = 3'h4;
   localparam logic [2:0] FL_H = 3'h5;
   localparam logic [2:0] FL_T = 3'h6;
   localparam logic [2:0] FL_I = 3'h7;
   // Low register of the X and Y pointer pairs
   localparam logic [4:0] PTR_X_LO = 5'h1A;
   localparam logic [4:0] PTR_Y_LO = 5'h1C;

   typedef enum logic [5:0] {
      OP_NOP = 6'h00,
      OP_BRANCH_IRQ_ON = 6'h01,
      OP_BRANCH_IRQ_OFF = 6'h02,
      OP_IO_BIT_SET = 6'h03,
      OP_IO_BIT_CLEAR = 6'h04,
      OP_LOGIC_LEFT_SHIFT = 6'h05,
      OP_LOGIC_RIGHT_SHIFT = 6'h06,
      OP_ROTATE_LEFT_CARRY = 6'h07,
      OP_ROTATE_RIGHT_CARRY = 6'h08,
      OP_ARITH_RIGHT_SHIFT = 6'h09,
      OP_NIBBLE_SWAP = 6'h0A,
      OP_FLAG_SET = 6'h0B,
      OP_FLAG_CLEAR = 6'h0C,
      OP_BIT_TO_TFLAG = 6'h0D,
      OP_TFLAG_TO_BIT = 6'h0E,
      OP_PAIR_COPY = 6'h0F,
      OP_INDIRECT_LOAD = 6'h10,
      OP_LOAD_POST_INC = 6'h11,
      OP_LOAD_PRE_DEC = 6'h12,
      OP_OFFSET_LOAD = 6'h13
   } cbx_op_type;

   // Command word as written to ADDR_CMD bits 23:0
   typedef struct packed {
      cbx_op_type op;
      logic [4:0] rd;
      logic [4:0] rr;
      logic [7:0] imm;
   } cbx_cmd_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_EXEC = 3'h2,
      ST_SECOND = 3'h4
   } cbx_state_type;
endpackage

/* src/cbx_exec.sv */
// Execution unit for branch-on-I, I/O bit, shift, T-bit, flag and indirect load commands
//
// Function
// RL1: Branch if I set, 1/2 cycles
// RL2: Branch if I clear, 1/2 cycles
// RL3: Set I/O bit in 2 cycles
// RL4: Clear I/O bit in 2 cycles
// RL5: Left shift, zero in, flags Z,C,N,V
// RL6: Right shift, zero in, flags Z,C,N,V
// RL7: Rotate left through carry, one cycle
// RL8: Rotate right through carry, one cycle
// RL9: Arithmetic right shift keeps sign bit
// RL10: Copy register bit into T flag
// RL11: Copy T flag into register bit
// RL12: Set or clear any single flag
// RL13: Load then increment X/Y pointer
// RL14: Decrement X/Y pointer then load
// RL15: Load from Y plus displacement
// RL16: Swap nibbles, flags untouched
// RL17: Copy register pair in one cycle
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module cbx_exec
   import cbx_pkg::*;
(
   input wire logic I_CLK_SYS,
   input wire logic I_ARST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic O_BUSY
);
   logic pready_reg;
   logic pslverr_reg;
   logic busy_reg;
   logic [31:0] prdata_reg;
   cbx_state_type state_reg;
   cbx_state_type state_next;
   cbx_cmd_type cmd_reg;
   logic [7:0] flags_reg;
   logic [15:0] pc_reg;
   logic [15:0] addr_reg;
   logic [7:0] rf_reg [0:31];
   logic [7:0] io_reg [0:63];
   logic [7:0] dm_reg [0:255];
   logic apb_access;
   logic wr_done;
   logic cmd_go;
   logic in_exec;
   logic in_second;
   logic take_branch;
   logic two_cycle;
   logic is_load;
   logic shift_c;
   logic [7:0] shift_res;
   logic [7:0] rd_val;
   logic [15:0] ptr_inc;
   logic [15:0] ptr_dec;
   logic [4:0] ptr_lo;
   logic [15:0] ptr_val;
   logic [15:0] br_target;

   // Window decode shared by read, write and error paths
   function automatic logic in_rf(input logic [11:0] a);
      return a[11:7] == RF_TAG;
   endfunction
   function automatic logic in_io(input logic [11:0] a);
      return a[11:8] == IO_TAG;
   endfunction
   function automatic logic in_dm(input logic [11:0] a);
      return a[11:10] == DM_TAG;
   endfunction

   // Flag update common to all five shift forms; S is left alone
   function automatic logic [7:0] shift_flags(input logic [7:0] res, input logic c,
                                              input logic [7:0] f);
      logic [7:0] nf;
      nf = f;
      nf[FL_C] = c;
      nf[FL_Z] = (res == 8'h00);
      nf[FL_N] = res[7];
      nf[FL_V] = res[7] ^ c;
      return nf;
   endfunction

   // APB phase qualifiers; one wait state before pready
   assign apb_access = I_PSEL & I_PENABLE & ~pready_reg;
   assign wr_done = I_PSEL & I_PENABLE & pready_reg & I_PWRITE;
   // A write already answered with an error must not start a command
   assign cmd_go = wr_done & (I_PADDR == ADDR_CMD) & (state_reg == ST_IDLE) & ~pslverr_reg;
   assign in_exec = (state_reg == ST_EXEC);
   assign in_second = (state_reg == ST_SECOND);

   // Operand fetch, shifter and pointer arithmetic
   always_comb
   begin
      rd_val = rf_reg[cmd_reg.rd];
      ptr_lo = (cmd_reg.rr[0] || cmd_reg.op == OP_OFFSET_LOAD) ? PTR_Y_LO : PTR_X_LO;
      ptr_val = {rf_reg[ptr_lo | 5'h01], rf_reg[ptr_lo]};
      ptr_inc = ptr_val + 16'h0001;
      ptr_dec = ptr_val - 16'h0001;
      br_target = pc_reg + {{8{cmd_reg.imm[7]}}, cmd_reg.imm} + 16'h0001;
      take_branch = (cmd_reg.op == OP_BRANCH_IRQ_ON && flags_reg[FL_I])
                 || (cmd_reg.op == OP_BRANCH_IRQ_OFF && !flags_reg[FL_I]);
      is_load = (cmd_reg.op == OP_INDIRECT_LOAD) || (cmd_reg.op == OP_LOAD_POST_INC)
             || (cmd_reg.op == OP_LOAD_PRE_DEC) || (cmd_reg.op == OP_OFFSET_LOAD);
      two_cycle = take_branch || is_load || (cmd_reg.op == OP_IO_BIT_SET)
               || (cmd_reg.op == OP_IO_BIT_CLEAR);
      shift_res = rd_val;
      shift_c = flags_reg[FL_C];
      case (cmd_reg.op)
         OP_LOGIC_LEFT_SHIFT:
         begin
            shift_res = {rd_val[6:0], 1'b0};
            shift_c = rd_val[7];
         end
         OP_LOGIC_RIGHT_SHIFT:
         begin
            shift_res = {1'b0, rd_val[7:1]};
            shift_c = rd_val[0];
         end
         OP_ROTATE_LEFT_CARRY:
         begin
            shift_res = {rd_val[6:0], flags_reg[FL_C]};
            shift_c = rd_val[7];
         end
         OP_ROTATE_RIGHT_CARRY:
         begin
            shift_res = {flags_reg[FL_C], rd_val[7:1]};
            shift_c = rd_val[0];
         end
         OP_ARITH_RIGHT_SHIFT:
         begin
            shift_res = {rd_val[7], rd_val[7:1]};
            shift_c = rd_val[0];
         end
         default:
         begin
            shift_res = rd_val;
            shift_c = flags_reg[FL_C];
         end
      endcase
   end

   // Sequencer: every command spends one cycle in EXEC, two-cycle ones add SECOND
   always_comb
   begin
      case (state_reg)
         ST_IDLE: state_next = cmd_go ? ST_EXEC : ST_IDLE;
         ST_EXEC: state_next = two_cycle ? ST_SECOND : ST_IDLE;
         ST_SECOND: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // State, busy flag and latched command
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         state_reg <= ST_IDLE;
         busy_reg <= 1'b0;
         cmd_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         busy_reg <= (state_next != ST_IDLE);
         if (cmd_go)
            cmd_reg <= I_PWDATA[23:0];
      end
   end

   // Program counter; relative target taken only when the I test passes
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
         pc_reg <= PC_RESET;
      else if (in_exec)
         // RL1 RL2: conditional relative branch
         pc_reg <= take_branch ? br_target : pc_reg + 16'h0001;
      else if (wr_done && I_PADDR == ADDR_PC && state_reg == ST_IDLE)
         pc_reg <= I_PWDATA[15:0];
   end

   // Status flags; execution wins over a software write in the same cycle
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
         flags_reg <= FLAGS_RESET;
      else if (in_exec)
      begin
         case (cmd_reg.op)
            // RL5 RL6 RL7 RL8 RL9: shift flag update
            OP_LOGIC_LEFT_SHIFT, OP_LOGIC_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY,
            OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT:
               flags_reg <= shift_flags(shift_res, shift_c, flags_reg);
            // RL12: single flag forced
            OP_FLAG_SET: flags_reg[cmd_reg.imm[2:0]] <= 1'b1;
            OP_FLAG_CLEAR: flags_reg[cmd_reg.imm[2:0]] <= 1'b0;
            // RL10: bit into T
            OP_BIT_TO_TFLAG: flags_reg[FL_T] <= rd_val[cmd_reg.imm[2:0]];
            default: flags_reg <= flags_reg;
         endcase
      end
      else if (wr_done && I_PADDR == ADDR_FLAGS)
         flags_reg <= I_PWDATA[7:0];
   end

   // Effective load address, fixed in EXEC and used in SECOND
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
         addr_reg <= 16'h0000;
      else if (in_exec)
      begin
         if (cmd_reg.op == OP_LOAD_PRE_DEC)
            addr_reg <= ptr_dec;
         else if (cmd_reg.op == OP_OFFSET_LOAD)
            // RL15: Y plus unsigned displacement
            addr_reg <= ptr_val + {10'h000, cmd_reg.imm[5:0]};
         else
            addr_reg <= ptr_val;
      end
   end

   // Register file; a loaded byte overrides a pointer update to the same register
   always_ff @(posedge I_CLK_SYS)
   begin
      if (wr_done && in_rf(I_PADDR) && state_reg == ST_IDLE)
         rf_reg[I_PADDR[6:2]] <= I_PWDATA[7:0];
      if (in_exec)
      begin
         case (cmd_reg.op)
            OP_LOGIC_LEFT_SHIFT, OP_LOGIC_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY,
            OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT:
               rf_reg[cmd_reg.rd] <= shift_res;
            // RL16: nibble exchange
            OP_NIBBLE_SWAP: rf_reg[cmd_reg.rd] <= {rd_val[3:0], rd_val[7:4]};
            // RL11: T into register bit
            OP_TFLAG_TO_BIT: rf_reg[cmd_reg.rd][cmd_reg.imm[2:0]] <= flags_reg[FL_T];
            // RL17: even pair copied at once
            OP_PAIR_COPY:
            begin
               rf_reg[cmd_reg.rd & 5'h1E] <= rf_reg[cmd_reg.rr & 5'h1E];
               rf_reg[cmd_reg.rd | 5'h01] <= rf_reg[cmd_reg.rr | 5'h01];
            end
            // RL14: pointer decremented before the read
            OP_LOAD_PRE_DEC:
            begin
               rf_reg[ptr_lo] <= ptr_dec[7:0];
               rf_reg[ptr_lo | 5'h01] <= ptr_dec[15:8];
            end
            default: rf_reg[cmd_reg.rd] <= rd_val;
         endcase
      end
      if (in_second && is_load)
      begin
         // RL13: pointer incremented after the read
         if (cmd_reg.op == OP_LOAD_POST_INC)
         begin
            rf_reg[ptr_lo] <= ptr_inc[7:0];
            rf_reg[ptr_lo | 5'h01] <= ptr_inc[15:8];
         end
         // RL13 RL14 RL15: memory byte into destination
         rf_reg[cmd_reg.rd] <= dm_reg[addr_reg[7:0]];
      end
   end

   // I/O space; bit change lands in SECOND, other bits kept
   always_ff @(posedge I_CLK_SYS)
   begin
      if (wr_done && in_io(I_PADDR))
         io_reg[I_PADDR[7:2]] <= I_PWDATA[7:0];
      // RL3 RL4: read-modify-write of one bit
      if (in_second && cmd_reg.op == OP_IO_BIT_SET)
         io_reg[cmd_reg.imm[5:0]][cmd_reg.rr[2:0]] <= 1'b1;
      else if (in_second && cmd_reg.op == OP_IO_BIT_CLEAR)
         io_reg[cmd_reg.imm[5:0]][cmd_reg.rr[2:0]] <= 1'b0;
   end

   // Data memory, only 256 bytes, so pointer bits above 7 alias
   always_ff @(posedge I_CLK_SYS)
   begin
      if (wr_done && in_dm(I_PADDR))
         dm_reg[I_PADDR[9:2]] <= I_PWDATA[7:0];
   end

   // APB answer: data and error registered on the same edge that raises pready
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else
      begin
         pready_reg <= apb_access;
         if (apb_access)
         begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            if (in_rf(I_PADDR))
               prdata_reg[7:0] <= rf_reg[I_PADDR[6:2]];
            else if (in_io(I_PADDR))
               prdata_reg[7:0] <= io_reg[I_PADDR[7:2]];
            else if (in_dm(I_PADDR))
               prdata_reg[7:0] <= dm_reg[I_PADDR[9:2]];
            else if (I_PADDR == ADDR_CMD)
            begin
               prdata_reg[23:0] <= cmd_reg;
               // Refuse a new command while one runs
               pslverr_reg <= I_PWRITE && (state_reg != ST_IDLE);
            end
            else if (I_PADDR == ADDR_FLAGS)
               prdata_reg[7:0] <= flags_reg;
            else if (I_PADDR == ADDR_PC)
               prdata_reg[15:0] <= pc_reg;
            else if (I_PADDR == ADDR_STAT)
               prdata_reg[0] <= busy_reg;
            else
               pslverr_reg <= 1'b1;
         end
      end
   end

   assign O_PRDATA = prdata_reg;
   assign O_PREADY = pready_reg;
   assign O_PSLVERR = pslverr_reg;
   assign O_BUSY = busy_reg;

   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_ARST_N);

   a_branch_irq_on_taken: assert property (in_exec && cmd_reg.op == OP_BRANCH_IRQ_ON && flags_reg[FL_I] // RL1
      |=> pc_reg == $past(br_target) && state_reg == ST_SECOND ##1 state_reg == ST_IDLE)
      else $error("branch on I set wrong");
   a_branch_irq_off_fall: assert property (in_exec && cmd_reg.op == OP_BRANCH_IRQ_OFF && flags_reg[FL_I] // RL2
      |=> pc_reg == $past(pc_reg) + 16'h0001 && state_reg == ST_IDLE && $stable(flags_reg))
      else $error("branch on I clear wrong");
   a_io_set_time: assert property (cmd_go && I_PWDATA[23:18] == OP_IO_BIT_SET // RL3
      |=> in_exec ##1 in_second ##1 state_reg == ST_IDLE)
      else $error("io bit set timing wrong");
   a_io_clr_flags: assert property (in_exec && cmd_reg.op == OP_IO_BIT_CLEAR // RL4
      |=> flags_reg == $past(flags_reg) [*2])
      else $error("io bit clear touched flags");
   a_lsl_carry: assert property (in_exec && cmd_reg.op == OP_LOGIC_LEFT_SHIFT // RL5
      |=> flags_reg[FL_C] == $past(rd_val[7]) && !flags_reg[FL_Z] == |$past(rd_val[6:0]))
      else $error("left shift flags wrong");
   a_lsr_neg: assert property (in_exec && cmd_reg.op == OP_LOGIC_RIGHT_SHIFT // RL6
      |=> !flags_reg[FL_N] && flags_reg[FL_V] == $past(rd_val[0]))
      else $error("right shift flags wrong");
   a_rol_carry: assert property (in_exec && cmd_reg.op == OP_ROTATE_LEFT_CARRY // RL7
      |=> flags_reg[FL_C] == $past(rd_val[7]) && flags_reg[FL_N] == $past(rd_val[6]))
      else $error("rotate left flags wrong");
   a_ror_sign: assert property (in_exec && cmd_reg.op == OP_ROTATE_RIGHT_CARRY // RL8
      |=> flags_reg[FL_N] == $past(flags_reg[FL_C]) && flags_reg[FL_C] == $past(rd_val[0]))
      else $error("rotate right flags wrong");
   a_asr_sign: assert property (in_exec && cmd_reg.op == OP_ARITH_RIGHT_SHIFT // RL9
      |=> flags_reg[FL_N] == $past(rd_val[7]) && flags_reg[FL_S] == $past(flags_reg[FL_S]))
      else $error("arithmetic shift flags wrong");
   a_bst_tflag: assert property (in_exec && cmd_reg.op == OP_BIT_TO_TFLAG // RL10
      |=> flags_reg[FL_T] == $past(rd_val[cmd_reg.imm[2:0]])
          && flags_reg[5:0] == $past(flags_reg[5:0]))
      else $error("bit to T wrong");
   a_bld_flags: assert property (in_exec && cmd_reg.op == OP_TFLAG_TO_BIT // RL11
      |=> $stable(flags_reg) && state_reg == ST_IDLE)
      else $error("T to bit changed flags");
   a_flag_force: assert property (in_exec && cmd_reg.op == OP_FLAG_SET // RL12
      |=> flags_reg[$past(cmd_reg.imm[2:0])] && state_reg == ST_IDLE)
      else $error("flag set failed");
   a_load_time: assert property (in_exec && is_load // RL13
      |=> in_second ##1 state_reg == ST_IDLE && $stable(flags_reg))
      else $error("load timing wrong");
   a_swap_flags: assert property (in_exec && cmd_reg.op == OP_NIBBLE_SWAP // RL16
      |=> $stable(flags_reg) && state_reg == ST_IDLE)
      else $error("swap changed flags");

   c_branch_irq_on_taken: cover property (in_exec && cmd_reg.op == OP_BRANCH_IRQ_ON && take_branch);
   c_post_inc: cover property (in_second && cmd_reg.op == OP_LOAD_POST_INC);
   c_io_set: cover property (in_second && cmd_reg.op == OP_IO_BIT_SET);
   c_refused: cover property (pslverr_reg && pready_reg && state_reg != ST_IDLE);
endmodule

/* testbench/cbx_apb_host.sv */
// APB host model that issues single register transfers to the execution block
`timescale 1ns/100ps
module cbx_apb_host
(
   input wire logic i_clk,
   input wire logic i_pready,
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [11:0] o_paddr,
   output logic [31:0] o_pwdata
);
   // Idle bus from time zero
   initial
   begin
      o_psel = 1'h0;
      o_penable = 1'h0;
      o_pwrite = 1'h0;
      o_paddr = 12'h000;
      o_pwdata = 32'h00000000;
   end

   // Setup, then access held until ready is seen; to flags a hung slave
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output bit to);
      int n;
      to = 1'b1;
      @(posedge i_clk);
      o_psel <= 1'h1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clk);
      o_penable <= 1'h1;
      // Ready sampled at the rising edge; request held until that edge
      for (n = 0; n < 16 && to; n++)
      begin
         @(posedge i_clk);
         if (i_pready === 1'h1)
            to = 1'b0;
      end
      // Released only after the completing edge
      o_psel <= 1'h0;
      o_penable <= 1'h0;
   endtask
endmodule

/* testbench/tb_cbx_exec.sv */
// Self-checking bench for the bit, shift, flag and load execution block
`timescale 1ns/100ps
module tb_cbx_exec
   import cbx_pkg::*;
();
   typedef struct {string name; logic [31:0] data; logic err; logic rd;} cbx_note_type;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   cbx_note_type notes[$];
   cbx_note_type note;
   int busy_q[$];
   int failures = 0, checked = 0, blen = 0, i;
   logic [7:0] v, f, e, k;
   logic [15:0] p, x, ea, r;
   logic [5:0] q;
   logic [4:0] d;
   logic [2:0] b;
   logic y, t;
   cbx_op_type op;

   // System clock, 50 ns period
   initial
   begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   cbx_exec dut
   (
      .I_CLK_SYS(clk),
      .I_ARST_N(arst_n),
      .I_PSEL(psel),
      .I_PENABLE(penable),
      .I_PWRITE(pwrite),
      .I_PADDR(paddr),
      .I_PWDATA(pwdata),
      .O_PRDATA(prdata),
      .O_PREADY(pready),
      .O_PSLVERR(pslverr),
      .O_BUSY(busy)
   );

   cbx_apb_host host
   (
      .i_clk(clk),
      .i_pready(pready),
      .o_psel(psel),
      .o_penable(penable),
      .o_pwrite(pwrite),
      .o_paddr(paddr),
      .o_pwdata(pwdata)
   );

   function automatic logic [11:0] ra(input logic [4:0] n);
      return 12'h100 + {5'h00, n, 2'h0};
   endfunction

   // Reference shifter: returns new flags over new register value
   function automatic logic [15:0] shref(input cbx_op_type o, input logic [7:0] a,
      input logic [7:0] g);
      logic [7:0] s;
      logic c;
      c = a[0];
      case (o)
         OP_LOGIC_LEFT_SHIFT: {c, s} = {a, 1'h0};
         OP_LOGIC_RIGHT_SHIFT: s = {1'h0, a[7:1]};
         OP_ROTATE_LEFT_CARRY: {c, s} = {a, g[FL_C]};
         OP_ROTATE_RIGHT_CARRY: s = {g[FL_C], a[7:1]};
         OP_ARITH_RIGHT_SHIFT: s = {a[7], a[7:1]};
         default: return {g, a[3:0], a[7:4]};
      endcase
      g[FL_C] = c;
      g[FL_Z] = (s == 8'h00);
      g[FL_N] = s[7];
      g[FL_V] = s[7] ^ c;
      return {g, s};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      check("notes left", 32'(notes.size() + busy_q.size()), 32'h00000000);
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Note the expected answer, then run the transfer on the host
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] dv,
      input string s, input logic er);
      bit to;
      cbx_note_type nt;
      nt.name = s;
      nt.data = dv;
      nt.err = er;
      nt.rd = !w;
      notes.push_back(nt);
      host.xfer(w, a, dv, to);
      if (to)
      begin
         failures++;
         end_of_test();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] dv);
      bus(1'h1, a, {24'h000000, dv}, "write", 1'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [15:0] dv, input string s);
      bus(1'h0, a, {16'h0000, dv}, s, 1'h0);
   endtask

   // Busy never outlasts two cycles, so four edges always cover it
   task automatic cmd(input cbx_op_type o, input logic [4:0] rdn, input logic [4:0] rrn,
      input logic [7:0] im, input int cyc);
      busy_q.push_back(cyc);
      bus(1'h1, ADDR_CMD, {8'h00, o, rdn, rrn, im}, "command", 1'h0);
      repeat (4) @(posedge clk);
   endtask

   // Compare each finished transfer with the oldest note and each busy pulse with the oldest busy_q entry
   always @(negedge clk)
   begin
      if (pready === 1'h1)
      begin
         note = notes.pop_front();
         check({note.name, " err"}, {31'h0, pslverr}, {31'h0, note.err});
         if (note.rd)
            check(note.name, prdata, note.data);
      end
      if (busy === 1'h1)
         blen++;
      else if (blen != 0)
      begin
         check("busy cycles", 32'(blen), 32'(busy_q.pop_front()));
         blen = 0;
      end
   end

   initial
   begin
      arst_n = 1'h0;
      void'($urandom(46747));
      repeat (6) @(posedge clk);
      arst_n <= 1'h1;
      rd(ADDR_FLAGS, 16'h0000, "flags");
      rd(ADDR_PC, 16'h0000, "pc");
      bus(1'h0, 12'h010, 32'h00000000, "unmapped", 1'h1);
      for (i = 5; i <= 10; i++)
      begin
         {v, f} = 16'($urandom);
         d = 5'($urandom_range(25));
         op = cbx_op_type'(i);
         wr(ra(d), v);
         wr(ADDR_FLAGS, f);
         cmd(op, d, 5'h00, 8'h00, 1);
         r = shref(op, v, f);
         rd(ra(d), {8'h00, r[7:0]}, "shift value");
         rd(ADDR_FLAGS, {8'h00, r[15:8]}, "shift flags");
      end
      // every flag set and cleared alone
      for (i = 0; i < 16; i++)
      begin
         f = 8'($urandom);
         e = f;
         e[i[2:0]] = (i < 8);
         wr(ADDR_FLAGS, f);
         cmd((i < 8) ? OP_FLAG_SET : OP_FLAG_CLEAR, 5'h00, 5'h00, {5'h00, i[2:0]}, 1);
         rd(ADDR_FLAGS, {8'h00, e}, "flag op");
      end
      // bit into T, then T into a neighbouring bit
      {v, f} = 16'($urandom);
      b = 3'($urandom);
      wr(ra(5'h07), v);
      wr(ADDR_FLAGS, f);
      cmd(OP_BIT_TO_TFLAG, 5'h07, 5'h00, {5'h00, b}, 1);
      f[FL_T] = v[b];
      rd(ADDR_FLAGS, {8'h00, f}, "t flag");
      cmd(OP_TFLAG_TO_BIT, 5'h07, 5'h00, {5'h00, b ^ 3'h1}, 1);
      v[b ^ 3'h1] = v[b];
      rd(ra(5'h07), {8'h00, v}, "t to bit");
      // branches on the interrupt flag, taken and not
      for (i = 0; i < 4; i++)
      begin
         {p, k, f} = 32'($urandom);
         f[FL_I] = i[0];
         t = (i < 2) ? i[0] : !i[0];
         wr(ADDR_PC, p[7:0]);
         wr(ADDR_FLAGS, f);
         cmd((i < 2) ? OP_BRANCH_IRQ_ON : OP_BRANCH_IRQ_OFF, 5'h00, 5'h00, k, t ? 2 : 1);
         x = {8'h00, p[7:0]} + 16'h0001 + (t ? {{8{k[7]}}, k} : 16'h0000);
         rd(ADDR_PC, x, "branch pc");
         rd(ADDR_FLAGS, {8'h00, f}, "branch flags");
      end
      // one I/O bit set, then another cleared
      for (i = 0; i < 2; i++)
      begin
         {q, b, v} = 17'($urandom);
         wr(12'h200 + {4'h0, q, 2'h0}, v);
         cmd(i ? OP_IO_BIT_CLEAR : OP_IO_BIT_SET, 5'h00, {2'h0, b}, {2'h0, q}, 2);
         v[b] = !i;
         rd(12'h200 + {4'h0, q, 2'h0}, {8'h00, v}, "io bit");
      end
      rd(ADDR_FLAGS, {8'h00, f}, "io flags");
      // plain, post-increment, pre-decrement and offset loads
      for (i = 16; i <= 19; i++)
      begin
         {p, q, v, y} = 31'($urandom);
         op = cbx_op_type'(i);
         y = y | (op == OP_OFFSET_LOAD);
         d = y ? PTR_Y_LO : PTR_X_LO;
         ea = (op == OP_LOAD_PRE_DEC) ? p - 16'h0001 : p;
         ea = (op == OP_OFFSET_LOAD) ? p + {10'h000, q} : ea;
         x = (op == OP_LOAD_POST_INC) ? p + 16'h0001 : ea;
         x = (op == OP_OFFSET_LOAD) ? p : x;
         wr(ra(d), p[7:0]);
         wr(ra(d + 5'h01), p[15:8]);
         wr(12'h400 + {2'h0, ea[7:0], 2'h0}, v);
         cmd(op, 5'h05, {4'h0, y}, {2'h0, q}, 2);
         rd(ra(5'h05), {8'h00, v}, "load value");
         rd(ra(d), {8'h00, x[7:0]}, "pointer low");
         rd(ra(d + 5'h01), {8'h00, x[15:8]}, "pointer high");
      end
      {v, e} = 16'($urandom);
      wr(ra(5'h0A), v);
      wr(ra(5'h0B), e);
      cmd(OP_PAIR_COPY, 5'h02, 5'h0A, 8'h00, 1);
      rd(ra(5'h02), {8'h00, v}, "pair low");
      rd(ra(5'h03), {8'h00, e}, "pair high");
      end_of_test();
   end
endmodule
